// File: rtl/tws_pkg.sv
// constants and carrier types for the two-word burst sram port
// assumes the x36 organisation; all pins reach the core through tws_pins_t
`default_nettype none
package tws_pkg;
  // ----------------------------------------------------------------
  // organisation
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int BADDR_W = ADDR_W + 1;
  localparam int DEPTH = 2 ** BADDR_W;
  // data bits that exist on this organisation; the x18 part would use 36'h0_0003_ffff
  localparam logic [DATA_W-1:0] DATA_USED = 36'hf_ffff_ffff;
  // ----------------------------------------------------------------
  // reset values, read phase codes and buffer full count
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] Q_RST = 36'h0_0000_0000;
  localparam logic [1:0] PH_IDLE = 2'h0;
  localparam logic [1:0] PH_ARMED = 2'h1;
  localparam logic [1:0] PH_SECOND = 2'h2;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic rd_sel_n;
    logic wr_sel_n;
    logic dll_off_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;
    logic [LANES-1:0] bwe_n;
  } tws_pins_t;
  typedef struct packed {
    logic [BADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] wen;
  } tws_wbeat_t;
  typedef enum {W_IDLE, W_HALF, W_PUSH0, W_PUSH1} tws_wstate_t;
endpackage
`default_nettype wire

// File: rtl/tws_sram_port.sv
// burst sram port core: samples the link pins, stores bursts, replays read bursts
// assumes clk runs much faster than the link clocks, so every link edge is seen
//
// Operation
// - lanes 0 and 1 gate data bits 0-8 and 9-17
// - lanes 2 and 3 gate data bits 18-26 and 27-35
// - a low lane enable writes its lane only inside a started write
// - first read word on output clock complement, second on true clock
// - both output clocks high: time reads from input clocks; keep them high
// - low dll disable bypasses the delay loop
// - read address and control on true clock, write data on both input clocks
// - low read select at true clock latches address and starts a read
// - read select ignored at the true clock edge after an accepted read
// - read address at true clock, write address at complement clock
// - every transaction moves exactly two words in one clock period
// - address ignored when neither port is selected
// - unused data inputs of narrower organisations are ignored
// - low write select at true clock latches and starts a write
// - burst appends an internal low bit: offset zero then one, count two
// - read and write sequencing run independently and concurrently
// - echo clocks toggle freely, matched to data, also while data floats
`default_nettype none
module tws_sram_port import tws_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  input wire logic dll_off_n,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] din,
  input wire logic [LANES-1:0] byte_write_enable_n,
  output logic [DATA_W-1:0] q_out,
  output logic q_oe,
  output logic echo_clk,
  output logic echo_clk_n,
  output logic dll_bypass
);
  // ----------------------------------------------------------------
  // reset release and pin sampling
  // ----------------------------------------------------------------
  logic rst_s1_r, rst_n;
  tws_pins_t pins, pin_s1_r, pin_s2_r, pin_s3_r;
  assign pins = '{k, k_n, c, c_n, rd_sel_n, wr_sel_n, dll_off_n, addr_in, din, byte_write_enable_n};

  // reset enters asynchronously but is released in step with clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // two stages before use; third copy for edge finding and tie detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end else begin
      pin_s1_r <= pins;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  logic k_rise, kn_rise, tied_r, oclk, oclk_n, oc_rise, ocn_rise;
  assign k_rise = pin_s2_r.k & ~pin_s3_r.k;
  assign kn_rise = pin_s2_r.k_n & ~pin_s3_r.k_n;
  // output reference falls back to the input pair when both output clocks sit high
  assign oclk = tied_r ? pin_s2_r.k : pin_s2_r.c;
  assign oclk_n = tied_r ? pin_s2_r.k_n : pin_s2_r.c_n;
  assign oc_rise = oclk & ~(tied_r ? pin_s3_r.k : pin_s3_r.c);
  assign ocn_rise = oclk_n & ~(tied_r ? pin_s3_r.k_n : pin_s3_r.c_n);

  // tie detection; the master promises no toggling once tied
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tied_r <= 1'b0;
    else tied_r <= pin_s2_r.c & pin_s2_r.c_n & pin_s3_r.c & pin_s3_r.c_n;
  end

  // ----------------------------------------------------------------
  // write capture
  // ----------------------------------------------------------------
  tws_wstate_t wst_r;
  logic [DATA_W-1:0] wd0_r, wd1_r;
  logic [LANES-1:0] we0_r, we1_r;
  logic [ADDR_W-1:0] waddr_r;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  tws_wbeat_t f_in, f_out;

  // beat 0 on the true edge, address and beat 1 on the complement edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wst_r <= W_IDLE;
      wd0_r <= Q_RST;
      wd1_r <= Q_RST;
      we0_r <= '0;
      we1_r <= '0;
      waddr_r <= '0;
    end else begin
      case (wst_r)
        W_IDLE: begin
          if (k_rise && !pin_s2_r.wr_sel_n) begin
            wd0_r <= pin_s2_r.din & DATA_USED;
            we0_r <= ~pin_s2_r.bwe_n;
            wst_r <= W_HALF;
          end
        end
        W_HALF: begin
          if (kn_rise) begin
            waddr_r <= pin_s2_r.addr;
            wd1_r <= pin_s2_r.din & DATA_USED;
            we1_r <= ~pin_s2_r.bwe_n;
            wst_r <= W_PUSH0;
          end
        end
        W_PUSH0: if (f_in_ready) wst_r <= W_PUSH1;
        W_PUSH1: if (f_in_ready) wst_r <= W_IDLE;
        default: wst_r <= W_IDLE;
      endcase
    end
  end

  // two pushes per burst: offset zero first, then offset one
  assign f_in_valid = (wst_r == W_PUSH0) || (wst_r == W_PUSH1);
  assign f_in.addr = {waddr_r, wst_r == W_PUSH1};
  assign f_in.data = (wst_r == W_PUSH1) ? wd1_r : wd0_r;
  assign f_in.wen = (wst_r == W_PUSH1) ? we1_r : we0_r;

  // ----------------------------------------------------------------
  // two-entry write buffer
  // ----------------------------------------------------------------
  tws_wbeat_t fifo_r [2];
  logic wp_r, rp_r;
  logic [1:0] cnt_r;
  logic rd_fetch_r;
  assign f_in_ready = cnt_r != FIFO_FULL;
  assign f_out_valid = cnt_r != 2'h0;
  // a read fetch owns the array for a cycle, so the drain stalls and the buffer absorbs
  assign f_out_ready = ~rd_fetch_r;
  assign f_out = fifo_r[rp_r];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
      fifo_r[0] <= '0;
      fifo_r[1] <= '0;
    end else begin
      if (f_in_valid && f_in_ready) begin
        fifo_r[wp_r] <= f_in;
        wp_r <= ~wp_r;
      end
      if (f_out_valid && f_out_ready) rp_r <= ~rp_r;
      cnt_r <= cnt_r + 2'(f_in_valid && f_in_ready) - 2'(f_out_valid && f_out_ready);
    end
  end

  // ----------------------------------------------------------------
  // storage array
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] lane_mask;
  assign lane_mask = {{LANE_W{f_out.wen[3]}}, {LANE_W{f_out.wen[2]}},
                      {LANE_W{f_out.wen[1]}}, {LANE_W{f_out.wen[0]}}};

  // lanes with a high enable keep their old contents
  always_ff @(posedge clk) begin
    if (f_out_valid && f_out_ready) begin
      mem[f_out.addr] <= (mem[f_out.addr] & ~lane_mask) | (f_out.data & lane_mask);
    end
  end

  // ----------------------------------------------------------------
  // read capture, runs beside the write path
  // ----------------------------------------------------------------
  logic rd_go, rd_skip_r;
  logic [ADDR_W-1:0] raddr_r;
  logic [DATA_W-1:0] rw0_r, rw1_r;
  logic [1:0] rph_r;
  assign rd_go = k_rise && !pin_s2_r.rd_sel_n && !rd_skip_r;

  // address only moves on an accepted read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_skip_r <= 1'b0;
      raddr_r <= '0;
      rd_fetch_r <= 1'b0;
    end else begin
      if (k_rise) rd_skip_r <= rd_go;
      if (rd_go) raddr_r <= pin_s2_r.addr;
      rd_fetch_r <= rd_go;
    end
  end

  // both words fetched together; next read is at least two input periods away
  always_ff @(posedge clk) begin
    if (rd_fetch_r) begin
      rw0_r <= mem[{raddr_r, 1'b0}];
      rw1_r <= mem[{raddr_r, 1'b1}];
    end
  end

  // ----------------------------------------------------------------
  // output launch
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] qa_r, qb_r;
  logic oea_r, oeb_r, eca_r, ecb_r, ecna_r, ecnb_r;

  // word 0 on complement edge, word 1 on true edge, float otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rph_r <= PH_IDLE;
      qa_r <= Q_RST;
      oea_r <= 1'b0;
    end else begin
      if (rd_fetch_r) rph_r <= PH_ARMED;
      if (ocn_rise) begin
        if (rph_r == PH_ARMED && !rd_fetch_r) begin
          qa_r <= rw0_r;
          oea_r <= 1'b1;
          rph_r <= PH_SECOND;
        end else oea_r <= 1'b0;
      end else if (oc_rise) begin
        if (rph_r == PH_SECOND) begin
          qa_r <= rw1_r;
          oea_r <= 1'b1;
          if (!rd_fetch_r) rph_r <= PH_IDLE;
        end else oea_r <= 1'b0;
      end
    end
  end

  // echo follows the reference level; delayed copies serve the bypass path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eca_r <= 1'b0;
      ecna_r <= 1'b0;
      qb_r <= Q_RST;
      oeb_r <= 1'b0;
      ecb_r <= 1'b0;
      ecnb_r <= 1'b0;
    end else begin
      eca_r <= oclk;
      ecna_r <= oclk_n;
      qb_r <= qa_r;
      oeb_r <= oea_r;
      ecb_r <= eca_r;
      ecnb_r <= ecna_r;
    end
  end

  // without the loop, outputs leave one clk later but stay aligned with echo
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dll_bypass <= 1'b0;
      q_out <= Q_RST;
      q_oe <= 1'b0;
      echo_clk <= 1'b0;
      echo_clk_n <= 1'b0;
    end else begin
      dll_bypass <= ~pin_s2_r.dll_off_n;
      q_out <= dll_bypass ? qb_r : qa_r;
      q_oe <= dll_bypass ? oeb_r : oea_r;
      echo_clk <= dll_bypass ? ecb_r : eca_r;
      echo_clk_n <= dll_bypass ? ecnb_r : ecna_r;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_lane_low: assert property (@(posedge clk) disable iff (!rst_n)
    f_out_valid |-> lane_mask[17:0] == {{9{f_out.wen[1]}}, {9{f_out.wen[0]}}})
    else $error("lanes 0-1 mask wrong");
  chk_lane_high: assert property (@(posedge clk) disable iff (!rst_n)
    f_out_valid |-> lane_mask[35:18] == {{9{f_out.wen[3]}}, {9{f_out.wen[2]}}})
    else $error("lanes 2-3 mask wrong");
  chk_write_start: assert property (@(posedge clk) disable iff (!rst_n)
    (wst_r == W_IDLE && k_rise && pin_s2_r.wr_sel_n) |=> wst_r == W_IDLE)
    else $error("write started without select");
  chk_burst_pair: assert property (@(posedge clk) disable iff (!rst_n)
    (f_in_valid && f_in_ready && !f_in.addr[0]) |-> ##[1:8] (f_in_valid && f_in.addr[0]))
    else $error("burst second beat missing");
  chk_read_skip: assert property (@(posedge clk) disable iff (!rst_n)
    (k_rise && rd_skip_r) |=> (!rd_fetch_r && $stable(raddr_r)))
    else $error("read accepted on ignored edge");
  chk_addr_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !rd_go |=> $stable(raddr_r))
    else $error("read address moved without read");
  chk_first_word: assert property (@(posedge clk) disable iff (!rst_n)
    (ocn_rise && rph_r == PH_ARMED && !rd_fetch_r && !dll_bypass) |-> ##2 (q_oe && q_out == $past(rw0_r, 2)))
    else $error("first word not launched");
  chk_idle_float: assert property (@(posedge clk) disable iff (!rst_n)
    (ocn_rise && rph_r == PH_IDLE && !rd_fetch_r && !dll_bypass && !$past(dll_bypass)) |-> ##2 !q_oe)
    else $error("data driven on idle beat");
  chk_echo_track: assert property (@(posedge clk) disable iff (!rst_n)
    (!dll_bypass && !$past(dll_bypass)) |-> echo_clk == $past(oclk, 2))
    else $error("echo clock not tracking");
  chk_tied_ref: assert property (@(posedge clk) disable iff (!rst_n)
    (tied_r && $past(tied_r, 2) && !dll_bypass && !$past(dll_bypass)) |-> echo_clk == $past(pin_s2_r.k, 2))
    else $error("tied mode not on input clock");
endmodule
`default_nettype wire

// File: verification/tws_master_model.sv
// link master model: free-running input clock pair, output clocks, selects, address, data, lane enables
// assumes clk is the 100 MHz system clock; one link period spans eight clk cycles
`default_nettype none
module tws_master_model import tws_pkg::*; (
  input wire logic clk,
  input wire logic tied,
  output logic k,
  output logic k_n,
  output logic c,
  output logic c_n,
  output logic rd_sel_n,
  output logic wr_sel_n,
  output logic [ADDR_W-1:0] addr_in,
  output logic [DATA_W-1:0] din,
  output logic [LANES-1:0] bwe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_r = 3'h0;
  logic pend = 1'b0;
  logic wr_q, rd_q, cw_r, kv;
  logic [ADDR_W-1:0] wa_q, ra_q, cwa_r;
  logic [DATA_W-1:0] d0_q, d1_q, cd1_r;
  logic [LANES-1:0] e0_q, e1_q, ce1_r;
  assign kv = (ph_r == 3'h7) || (ph_r < 3'h3);
  initial begin
    {k, k_n, c, c_n, rd_sel_n, wr_sel_n, bwe_n} = 10'h17f;
    addr_in = '0;
    din = '0;
    // no write pending before the first burst, so idle lines stay known
    cw_r = 1'b0;
  end
  // hands one burst over; returns once its first beat is on the pins
  task automatic burst(input logic wr, input logic rd, input logic [ADDR_W-1:0] wa, input logic [ADDR_W-1:0] ra,
                       input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1, input logic [LANES-1:0] e0,
                       input logic [LANES-1:0] e1);
    @(negedge clk);
    {wr_q, rd_q, wa_q, ra_q, d0_q, d1_q, e0_q, e1_q} = {wr, rd, wa, ra, d0, d1, e0, e1};
    pend = 1'b1;
    while (pend) @(posedge clk);
  endtask
  // pins move two clk away from any link edge so the device's samplers never see them mid-change
  always @(posedge clk) begin
    ph_r <= ph_r + 3'h1;
    k <= kv;
    k_n <= ~kv;
    c <= tied | kv; // held high throughout a tied run
    c_n <= tied | ~kv;
    if (ph_r == 3'h5) begin
      // first beat, for the coming k rise; idle lines keep changing so stale values never pass
      rd_sel_n <= ~(pend & rd_q);
      wr_sel_n <= ~(pend & wr_q);
      addr_in <= pend ? ra_q : ~addr_in;
      din <= pend ? d0_q : ~din;
      bwe_n <= pend ? e0_q : 4'hf; // one enable set per beat
      cw_r <= pend & wr_q;
      {cwa_r, cd1_r, ce1_r} <= {wa_q, d1_q, e1_q};
      pend <= 1'b0;
    end else if (ph_r == 3'h1) begin
      // second beat, for the k_n rise
      {rd_sel_n, wr_sel_n} <= 2'h3;
      addr_in <= cw_r ? cwa_r : ~addr_in;
      din <= cw_r ? cd1_r : ~din;
      bwe_n <= cw_r ? ce1_r : 4'hf;
    end
  end
endmodule
`default_nettype wire

// File: verification/tws_sram_port_test.sv
// self-checking bench: bursts, lane enables, read refusal, concurrency, bypass, tied output clocks
// assumes the master model paces the link; expected words come from a local copy of the array
`default_nettype none
module tws_sram_port_test import tws_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, dll_off_n, tied, k, k_n, c, c_n, rd_sel_n, wr_sel_n, q_oe, echo_clk, echo_clk_n, dll_bypass;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] din, q_out;
  logic [LANES-1:0] bwe_n;
  logic [DATA_W-1:0] ref_mem [logic [BADDR_W-1:0]];
  logic [LANES-1:0] pats [6] = '{4'he, 4'hd, 4'hb, 4'h7, 4'ha, 4'hf};
  int num_errors = 0;
  int checks = 0;
  tws_sram_port i_dut (.clk(clk), .rstn(rstn), .k(k), .k_n(k_n), .c(c), .c_n(c_n), .rd_sel_n(rd_sel_n),
    .wr_sel_n(wr_sel_n), .dll_off_n(dll_off_n), .addr_in(addr_in), .din(din), .byte_write_enable_n(bwe_n),
    .q_out(q_out), .q_oe(q_oe), .echo_clk(echo_clk), .echo_clk_n(echo_clk_n), .dll_bypass(dll_bypass));
  tws_master_model i_mst (.clk(clk), .tied(tied), .k(k), .k_n(k_n), .c(c), .c_n(c_n), .rd_sel_n(rd_sel_n),
    .wr_sel_n(wr_sel_n), .addr_in(addr_in), .din(din), .bwe_n(bwe_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check_word(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // lane l owns bits 9l..9l+8 and is written only when its enable is low
  function automatic void merge(input logic [BADDR_W-1:0] ba, input logic [DATA_W-1:0] d, input logic [LANES-1:0] e);
    logic [DATA_W-1:0] w;
    w = ref_mem.exists(ba) ? ref_mem[ba] : {DATA_W{1'bx}};
    for (int l = 0; l < LANES; l++) begin
      if (!e[l]) w[l*LANE_W +: LANE_W] = d[l*LANE_W +: LANE_W];
    end
    ref_mem[ba] = w;
  endfunction
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1,
                    input logic [LANES-1:0] e0, input logic [LANES-1:0] e1);
    i_mst.burst(1'b1, 1'b0, a, a, d0, d1, e0, e1);
    merge({a, 1'b0}, d0, e0);
    merge({a, 1'b1}, d1, e1);
  endtask
  // waits for a read burst, takes both words mid-stand, then expects the bus to float
  task automatic collect(input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    while (q_oe !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) check_bit("read start", 1'b1, q_oe);
    tick(2);
    check_word("word0", ref_mem[{a, 1'b0}], q_out);
    tick(4);
    check_word("word1", ref_mem[{a, 1'b1}], q_out);
    tick(4);
    check_bit("float after burst", 1'b0, q_oe);
    tick(8);
  endtask
  // again: read select is low once more at the next k rise with another address, which must be ignored
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic again);
    fork
      begin
        i_mst.burst(1'b0, 1'b1, a, a, '0, '0, 4'hf, 4'hf);
        if (again) i_mst.burst(1'b0, 1'b1, ~a, ~a, '0, '0, 4'hf, 4'hf);
      end
      collect(a);
    join
  endtask
  // both echo outputs toggle once per half link period and stay in antiphase
  task automatic echo_count;
    int n;
    int m;
    int s;
    logic last;
    logic last_n;
    n = 0;
    m = 0;
    s = 0;
    last = echo_clk;
    last_n = echo_clk_n;
    repeat (64) begin
      @(posedge clk);
      if (echo_clk !== last) n++;
      if (echo_clk_n !== last_n) m++;
      if (echo_clk_n === echo_clk) s++;
      last = echo_clk;
      last_n = echo_clk_n;
    end
    check_word("echo toggles", 36'h0_0000_0010, DATA_W'(n));
    check_word("echo_n toggles", 36'h0_0000_0010, DATA_W'(m));
    check_word("echo in phase", 36'h0_0000_0000, DATA_W'(s));
  endtask
  task automatic do_reset;
    rstn <= 1'b0;
    tick(8);
    rstn <= 1'b1;
    tick(16);
    check_bit("idle float", 1'b0, q_oe);
  endtask
  // each enable pattern leaves its disabled lanes at the previous contents
  task automatic lanes_chk;
    for (int i = 0; i < 6; i++) begin
      wr(18'h3ffff, {LANE_W{pats[i]}}, ~{LANE_W{pats[i]}}, pats[i], ~pats[i]);
      tick(16);
      rd_chk(18'h3ffff, 1'b0);
    end
  endtask
  // read of one address while a write to another starts at the same k rise
  task automatic both_chk;
    fork
      begin
        i_mst.burst(1'b1, 1'b1, 18'h00001, 18'h00000, 36'h3_3333_3333, 36'hc_cccc_cccc, 4'h0, 4'h0);
        merge({18'h00001, 1'b0}, 36'h3_3333_3333, 4'h0);
        merge({18'h00001, 1'b1}, 36'hc_cccc_cccc, 4'h0);
      end
      collect(18'h00000);
    join
    rd_chk(18'h00001, 1'b0);
  endtask
  // bypassed delay loop: status shows it, read words and echo follow one clk later
  task automatic bypass_chk;
    dll_off_n <= 1'b0;
    tick(8);
    check_bit("bypass", 1'b1, dll_bypass);
    rd_chk(18'h00001, 1'b0);
    echo_count();
    dll_off_n <= 1'b1;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    dll_off_n = 1'b1;
    tied = 1'b0;
    do_reset();
    wr(18'h00000, 36'h1_2345_6789, 36'h9_8765_4321, 4'h0, 4'h0);
    wr(18'h3ffff, 36'ha_aaaa_aaaa, 36'h5_5555_5555, 4'h0, 4'h0);
    wr(18'h15a5a, 36'hf_0f0f_0f0f, 36'h0_f0f0_f0f0, 4'h0, 4'h0);
    tick(16);
    rd_chk(18'h00000, 1'b0);
    rd_chk(18'h3ffff, 1'b1);
    lanes_chk();
    tick(40);
    rd_chk(18'h15a5a, 1'b0);
    both_chk();
    echo_count();
    bypass_chk();
    tied <= 1'b1;
    do_reset();
    wr(18'h2aaaa, 36'h7_1357_9bdf, 36'h8_2468_ace0, 4'h0, 4'h0);
    tick(16);
    rd_chk(18'h2aaaa, 1'b0);
    echo_count();
    final_report();
  end
  initial begin
    tick(20000);
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
